// File: common/pll_guard_pkg.sv
// shared constants for the clock configuration guard block
package pll_guard_pkg;
    // register indices; byte address is four times the index
    localparam logic [11:0] IDX_IRC_TRIM_HI = 12'h2F2;
    localparam logic [11:0] IDX_IRC_TRIM_LO = 12'h2F3;
    localparam logic [11:0] IDX_LOOP_MULT = 12'h2F4;
    localparam logic [11:0] IDX_REF_DIV = 12'h2F5;
    localparam logic [11:0] IDX_POST_DIV = 12'h2F6;
    localparam logic [11:0] IDX_LOOP_FLAGS = 12'h2F7;
    localparam logic [11:0] IDX_LOOP_IRQ_EN = 12'h2F8;
    localparam logic [11:0] IDX_CLOCK_SEL = 12'h2F9;
    localparam logic [11:0] IDX_LOOP_CTRL = 12'h2F1;
    localparam logic [11:0] IDX_EXT_OSC = 12'h2FA;
    localparam logic [11:0] IDX_GUARD = 12'h2FB;
    localparam logic [11:0] IDX_TEST_TWO = 12'h2FC;
    // reset values
    localparam logic [7:0] RST_LOOP_MULT = 8'h5F; // vco range 01, mult 0x1F
    localparam logic [7:0] RST_REF_DIV = 8'h00;
    localparam logic [4:0] RST_POST_DIV = 5'h03;
    localparam logic [7:0] RST_CLOCK_SEL = 8'h80; // loop drives bus
    localparam logic [7:0] RST_EXT_OSC = 8'h00;
    localparam logic [7:0] RST_LOOP_CTRL = 8'h00;
    localparam logic [7:0] RST_IRC_TRIM = 8'h00;
    localparam logic [7:0] RST_GUARD = 8'h00;
    localparam logic [7:0] RST_TEST_TWO = 8'h00;
    // magic values
    localparam logic [7:0] GUARD_OPEN_KEY = 8'h26;
    localparam logic [7:0] TEST_UNLOCK_KEY = 8'hE3;
    // field positions
    localparam int POS_GUARD = 0;
    localparam int POS_AUX_MAP = 0;
    localparam int POS_IO_OK = 3;
    localparam int POS_FLASH_OK = 4;
    localparam int POS_CORE_OK = 5;
    localparam int POS_BUS_SEL = 7;
    localparam int POS_OSC_EN = 7;
    localparam int POS_OSC_PINS = 5;
    localparam int POS_LOCK = 3;
    localparam int POS_LOCK_FLAG = 4;
    localparam int POS_LOCK_IE = 4;
    // frequencies in kHz
    localparam int FREQ_W = 24;
    localparam logic [23:0] IRC_KHZ = 24'h0003E8; // 1.0 MHz
    localparam int LOCK_SHIFT = 6; // in-tolerance band ref/64
    localparam int UNLOCK_SHIFT = 4; // out-of-tolerance band ref/16
    localparam logic [23:0] VCO_STEP_KHZ = 24'h000010;
endpackage

// File: hw/pll_loop_model.sv
// behavioural phase-locked loop: vco, feedback, lock detector, post divider
`timescale 1ns/1ps
module pll_loop_model
    import pll_guard_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // settings
    input wire logic [FREQ_W-1:0] ref_khz,
    input wire logic [5:0] loop_mult_setting,
    input wire logic [4:0] output_divider,
    // loop state
    output logic [FREQ_W-1:0] vco_khz,
    output logic [FREQ_W-1:0] fb_khz,
    output logic [FREQ_W-1:0] pll_khz,
    output logic locked,
    output logic phase_up,
    output logic phase_dn
);
    logic [FREQ_W-1:0] next_fb;
    logic [FREQ_W-1:0] diff;
    logic [6:0] fb_div;

    // feedback = vco / (2*(mult+1)), the fixed /2 folded in
    always_comb begin
        fb_div = {1'b0, loop_mult_setting} + 7'h01;
        next_fb = (vco_khz >> 1) / FREQ_W'(fb_div);
        diff = (next_fb > ref_khz) ? next_fb - ref_khz : ref_khz - next_fb;
    end

    // correction pulses steer the vco
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vco_khz <= '0;
            fb_khz <= '0;
            phase_up <= 1'b0;
            phase_dn <= 1'b0;
        end else begin
            fb_khz <= next_fb;
            phase_up <= next_fb < ref_khz;
            phase_dn <= next_fb > ref_khz;
            if (next_fb < ref_khz) begin
                vco_khz <= vco_khz + VCO_STEP_KHZ;
            end else if (next_fb > ref_khz && vco_khz >= VCO_STEP_KHZ) begin
                vco_khz <= vco_khz - VCO_STEP_KHZ;
            end
        end
    end

    // lock detector with hysteresis
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            locked <= 1'b0;
        end else if (!locked && diff <= (ref_khz >> LOCK_SHIFT)) begin
            locked <= 1'b1;
        end else if (locked && diff > (ref_khz >> UNLOCK_SHIFT)) begin
            locked <= 1'b0;
        end
    end

    // post divider or fixed /4 while unlocked
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_khz <= '0;
        end else if (locked) begin
            pll_khz <= vco_khz
                / FREQ_W'({1'b0, output_divider} + 6'h01);
        end else begin
            pll_khz <= vco_khz >> 2;
        end
    end
endmodule

// File: hw/pll_clock_config_guard.sv
// clock configuration guard, factory test register and loop control
// Function
// - writing 0x26 to guard register clears guard, other values set it
// - guard high blocks clock configuration writes; guard resets low
// - guard register always accessible, bits 7..1 read zero
// - test register written only in special mode after 0xE3 unlock
// - three supply status bits read-only, high when ok or reduced perf
// - aux clock to pin when mapped, timer enabled, no external access
// - reference is 1.0 MHz internal clock when oscillator disabled
// - with oscillator, reference is xtal divided by divider plus one
// - vco equals twice reference times multiplier setting plus one
// - locked output equals vco divided by output divider plus one
// - unlocked output equals vco divided by four
// - bus clock is loop output halved when loop is bus source
// - feedback compared against reference, correction pulses from it
// - lock flag sets inside lock band, clears outside unlock band
// - lock flag is read-only
// - lock enable high raises request on every lock flag toggle
// - guard covers multiplier, ref divider, select, loop, trim, osc
// - oscillator register writable only when unguarded and loop selected
// - after reset internal reference, 64 MHz vco, output divider 0x03
`timescale 1ns/1ps
module pll_clock_config_guard
    import pll_guard_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // asynchronous pins
    input wire logic special_mode,
    input wire logic core_lvr_above,
    input wire logic flash_lvr_above,
    input wire logic io_lvr_above,
    input wire logic reduced_perf_state,
    input wire logic periodic_timer_en,
    input wire logic periodic_external_access,
    input wire logic aux_clock_in,
    input wire logic [FREQ_W-1:0] xtal_khz,
    // clock results
    output logic [FREQ_W-1:0] pll_ref_khz,
    output logic [FREQ_W-1:0] loop_vco_khz,
    output logic [FREQ_W-1:0] loop_output_khz,
    output logic [FREQ_W-1:0] bus_khz,
    output logic pll_locked,
    output logic phase_up,
    output logic phase_dn,
    output logic lock_irq,
    output logic aux_clock_pin
);
    localparam int SYNC_W = 8 + FREQ_W;

    logic [SYNC_W-1:0] sync_a;
    logic [SYNC_W-1:0] sync_b;
    logic special_s;
    logic core_ok_s;
    logic flash_ok_s;
    logic io_ok_s;
    logic rpm_s;
    logic timer_en_s;
    logic ext_acc_s;
    logic aclk_s;
    logic [FREQ_W-1:0] xtal_s;
    logic [7:0] loop_mult;
    logic [7:0] ref_div;
    logic [4:0] post_div;
    logic [7:0] clock_sel;
    logic [7:0] loop_ctrl;
    logic [7:0] irc_trim_hi;
    logic [7:0] irc_trim_lo;
    logic [7:0] ext_osc_config;
    logic cfg_guard;
    logic test_armed;
    logic aux_clock_pin_map;
    logic pll_tolerance_irq_en;
    logic lock_flag;
    logic lock_prev;
    logic [FREQ_W-1:0] fb_khz;
    logic wr;
    logic [11:0] idx;
    logic [7:0] wd;
    logic hit;
    logic [7:0] next_rdata;
    logic bus_source_sel;
    logic ext_osc_en;
    logic open_cfg;
    logic lock_toggle;

    // two-flop synchronisers for every pin input
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= {special_mode, core_lvr_above, flash_lvr_above,
                io_lvr_above, reduced_perf_state, periodic_timer_en,
                periodic_external_access, aux_clock_in, xtal_khz};
            sync_b <= sync_a;
        end
    end

    assign {special_s, core_ok_s, flash_ok_s, io_ok_s, rpm_s, timer_en_s,
        ext_acc_s, aclk_s, xtal_s} = sync_b;

    // access decode; byte address is index times four
    assign idx = {2'b00, paddr[11:2]};
    assign wd = pwdata[7:0];
    assign wr = psel && penable && pwrite && pready;
    assign bus_source_sel = clock_sel[POS_BUS_SEL];
    assign ext_osc_en = ext_osc_config[POS_OSC_EN];
    assign open_cfg = !cfg_guard;

    // read mux and address hit
    always_comb begin
        hit = 1'b1;
        next_rdata = 8'h00;
        case (idx)
            IDX_LOOP_MULT: next_rdata = loop_mult;
            IDX_REF_DIV: next_rdata = ref_div;
            IDX_POST_DIV: next_rdata = {3'b000, post_div};
            IDX_LOOP_FLAGS: next_rdata = {3'b000, lock_flag, pll_locked,
                3'b000};
            IDX_LOOP_IRQ_EN: next_rdata = {3'b000, pll_tolerance_irq_en,
                4'h0};
            IDX_CLOCK_SEL: next_rdata = clock_sel;
            IDX_LOOP_CTRL: next_rdata = loop_ctrl;
            IDX_IRC_TRIM_HI: next_rdata = irc_trim_hi;
            IDX_IRC_TRIM_LO: next_rdata = irc_trim_lo;
            IDX_EXT_OSC: next_rdata = ext_osc_config;
            IDX_GUARD: next_rdata = {7'h00, cfg_guard};
            IDX_TEST_TWO: next_rdata = {2'b00, core_ok_s | rpm_s,
                flash_ok_s | rpm_s, io_ok_s | rpm_s, 2'b00,
                aux_clock_pin_map};
            default: hit = 1'b0;
        endcase
    end

    // apb answer: one wait-free access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            if (psel && !penable && !pwrite) begin
                prdata <= {24'h000000, next_rdata};
            end
        end
    end

    // guard latch, writable at any time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_guard <= RST_GUARD[POS_GUARD];
        end else if (wr && idx == IDX_GUARD) begin
            cfg_guard <= (wd != GUARD_OPEN_KEY);
        end
    end

    // guarded clock configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loop_mult <= RST_LOOP_MULT;
            ref_div <= RST_REF_DIV;
            clock_sel <= RST_CLOCK_SEL;
            loop_ctrl <= RST_LOOP_CTRL;
            irc_trim_hi <= RST_IRC_TRIM;
            irc_trim_lo <= RST_IRC_TRIM;
        end else if (wr && open_cfg) begin
            if (idx == IDX_LOOP_MULT) loop_mult <= wd;
            if (idx == IDX_REF_DIV) ref_div <= {wd[7:6], 2'b00, wd[3:0]};
            if (idx == IDX_CLOCK_SEL) clock_sel <= wd;
            if (idx == IDX_LOOP_CTRL) loop_ctrl <= wd;
            if (idx == IDX_IRC_TRIM_HI) irc_trim_hi <= wd;
            if (idx == IDX_IRC_TRIM_LO) irc_trim_lo <= wd;
        end
    end

    // oscillator config needs the loop selected too; pins bit is sticky
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_osc_config <= RST_EXT_OSC;
        end else if (wr && idx == IDX_EXT_OSC && open_cfg
            && bus_source_sel) begin
            ext_osc_config <= {wd[7:6], wd[7] | ext_osc_config[POS_OSC_PINS],
                wd[4:0]};
        end
    end

    // unguarded post divider and lock interrupt enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            post_div <= RST_POST_DIV;
            pll_tolerance_irq_en <= 1'b0;
        end else if (wr) begin
            if (idx == IDX_POST_DIV) post_div <= wd[4:0];
            if (idx == IDX_LOOP_IRQ_EN) begin
                pll_tolerance_irq_en <= wd[POS_LOCK_IE];
            end
        end
    end

    // factory test register: arm with key, then any number of writes in special mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            test_armed <= 1'b0;
            aux_clock_pin_map <= RST_TEST_TWO[POS_AUX_MAP];
        end else if (wr && idx == IDX_TEST_TWO) begin
            if (wd == TEST_UNLOCK_KEY) begin
                test_armed <= 1'b1;
            end else if (test_armed && special_s) begin
                aux_clock_pin_map <= wd[POS_AUX_MAP];
            end
        end
    end

    // aux clock routed to pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_clock_pin <= 1'b0;
        end else begin
            aux_clock_pin <= aux_clock_pin_map && timer_en_s && !ext_acc_s
                && aclk_s;
        end
    end

    // loop reference selection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_ref_khz <= IRC_KHZ;
        end else if (ext_osc_en) begin
            pll_ref_khz <= xtal_s
                / FREQ_W'({1'b0, ref_div[3:0]} + 5'h01);
        end else begin
            pll_ref_khz <= IRC_KHZ;
        end
    end

    pll_loop_model u_loop (
        .pclk(pclk),
        .presetn(presetn),
        .ref_khz(pll_ref_khz),
        .loop_mult_setting(loop_mult[5:0]),
        .output_divider(post_div),
        .vco_khz(loop_vco_khz),
        .fb_khz(fb_khz),
        .pll_khz(loop_output_khz),
        .locked(pll_locked),
        .phase_up(phase_up),
        .phase_dn(phase_dn)
    );

    // bus clock derivation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_khz <= '0;
        end else if (bus_source_sel) begin
            bus_khz <= loop_output_khz >> 1;
        end else begin
            bus_khz <= xtal_s;
        end
    end

    // lock change flag, set wins over write-one clear
    assign lock_toggle = pll_locked != lock_prev;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_prev <= 1'b0;
            lock_flag <= 1'b0;
            lock_irq <= 1'b0;
        end else begin
            lock_prev <= pll_locked;
            lock_flag <= lock_toggle || (lock_flag && !(wr
                && idx == IDX_LOOP_FLAGS && wd[POS_LOCK_FLAG]));
            lock_irq <= pll_tolerance_irq_en && (lock_toggle
                || (lock_flag && !(wr && idx == IDX_LOOP_FLAGS
                && wd[POS_LOCK_FLAG])));
        end
    end

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence guard_write_key;
        wr && idx == IDX_GUARD && wd == GUARD_OPEN_KEY;
    endsequence
    sequence guard_write_other;
        wr && idx == IDX_GUARD && wd != GUARD_OPEN_KEY;
    endsequence

    chk_guard_opens: assert property (guard_write_key |=> !cfg_guard)
        else $error("guard not cleared by key");
    chk_guard_closes: assert property (guard_write_other |=> cfg_guard)
        else $error("guard not set by other value");
    chk_guard_blocks_mult: assert property (wr && cfg_guard
        && idx == IDX_LOOP_MULT |=> $stable(loop_mult))
        else $error("guarded multiplier write took effect");
    chk_guard_readback: assert property (pready && !pwrite
        && idx == IDX_GUARD |-> prdata[7:1] == 7'h00 && prdata[0] == cfg_guard)
        else $error("guard readback wrong");
    chk_test_needs_key: assert property (wr && idx == IDX_TEST_TWO
        && (!test_armed || !special_s) |=> $stable(aux_clock_pin_map))
        else $error("test register written while locked");
    chk_osc_write_gate: assert property (wr && idx == IDX_EXT_OSC
        && (cfg_guard || !bus_source_sel) |=> $stable(ext_osc_config))
        else $error("oscillator write not ignored");
    chk_unlocked_quarter: assert property (!pll_locked
        |=> loop_output_khz == ($past(loop_vco_khz) >> 2))
        else $error("unlocked output not vco over four");
    chk_bus_half: assert property (bus_source_sel
        |=> bus_khz == ($past(loop_output_khz) >> 1))
        else $error("bus clock not half of loop output");
    chk_ref_internal: assert property (!ext_osc_en
        |=> pll_ref_khz == IRC_KHZ)
        else $error("reference not internal clock");
    chk_lock_irq_toggle: assert property (pll_tolerance_irq_en
        && $changed(pll_locked) |=> ##[0:1] lock_irq)
        else $error("lock toggle raised no request");
endmodule

// File: tb/tb_pll_clock_config_guard.sv
// self-checking bench for the clock configuration guard block
`timescale 1ns/1ps
module tb_pll_clock_config_guard;
    import pll_guard_pkg::*;
    // clock, reset and apb
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    // pins
    logic special_mode, core_lvr_above, flash_lvr_above, io_lvr_above;
    logic reduced_perf_state, periodic_timer_en, periodic_external_access;
    logic aux_clock_in, aux_clock_pin, pll_locked, phase_up, phase_dn;
    logic lock_irq;
    logic [FREQ_W-1:0] xtal_khz, pll_ref_khz, loop_vco_khz;
    logic [FREQ_W-1:0] loop_output_khz, bus_khz;
    int err_count = 0;
    int num_checks = 0;

    pll_clock_config_guard u_pll_clock_config_guard (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .special_mode(special_mode),
        .core_lvr_above(core_lvr_above), .flash_lvr_above(flash_lvr_above),
        .io_lvr_above(io_lvr_above), .reduced_perf_state(reduced_perf_state),
        .periodic_timer_en(periodic_timer_en),
        .periodic_external_access(periodic_external_access),
        .aux_clock_in(aux_clock_in), .xtal_khz(xtal_khz),
        .pll_ref_khz(pll_ref_khz), .loop_vco_khz(loop_vco_khz),
        .loop_output_khz(loop_output_khz), .bus_khz(bus_khz),
        .pll_locked(pll_locked), .phase_up(phase_up), .phase_dn(phase_dn),
        .lock_irq(lock_irq), .aux_clock_pin(aux_clock_pin)
    );

    // 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // compare and count
    task automatic check(input logic [31:0] seen, exp, input string msg);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: %s got %0h want %0h", $time, msg,
                seen, exp);
        end
    endtask

    // one apb transfer, waits for pready without a bound
    task automatic apb(input logic wr, input logic [11:0] idx,
        input logic [7:0] wd, output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx[9:0], 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        // waits for the answer; only the watchdog ends a hang
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // slave answers in the first access cycle, no wait states
        check(n, 1, "pready wait");
    endtask

    task automatic wr(input logic [11:0] idx, input logic [7:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, idx, d, rd, err);
    endtask

    task automatic rdchk(input logic [11:0] idx, input logic [7:0] exp);
        logic [31:0] rd;
        logic err;
        apb(1'b0, idx, 8'h00, rd, err);
        check(rd, {24'h000000, exp}, "read data");
        check(err, 1'b0, "read error flag");
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic wait_lock(input logic exp);
        int n;
        n = 0;
        while (pll_locked !== exp && n < 20000) begin
            @(posedge pclk);
            n++;
        end
        check(pll_locked, exp, "lock state");
    endtask

    // output follows vco one cycle later, bus one more
    task automatic out_ratio(input int div);
        logic [FREQ_W-1:0] v;
        @(posedge pclk);
        v = loop_vco_khz;
        @(posedge pclk);
        check(loop_output_khz, v / div, "loop output");
        v = loop_output_khz;
        @(posedge pclk);
        check(bus_khz, v / 2, "bus clock");
    endtask

    task automatic t_reset;
        check(pll_ref_khz, IRC_KHZ, "reset reference");
        rdchk(IDX_GUARD, 8'h00);
        rdchk(IDX_LOOP_MULT, 8'h5F);
        rdchk(IDX_POST_DIV, 8'h03);
        rdchk(IDX_CLOCK_SEL, 8'h80);
        rdchk(IDX_REF_DIV, 8'h00);
        out_ratio(4);
        $display("test reset done");
    endtask

    task automatic t_guard;
        wr(IDX_GUARD, 8'h11);
        rdchk(IDX_GUARD, 8'h01);
        wr(IDX_LOOP_MULT, 8'h03);
        rdchk(IDX_LOOP_MULT, 8'h5F);
        wr(IDX_CLOCK_SEL, 8'h00);
        rdchk(IDX_CLOCK_SEL, 8'h80);
        wr(IDX_GUARD, 8'h26);
        rdchk(IDX_GUARD, 8'h00);
        wr(IDX_IRC_TRIM_HI, 8'h0A);
        rdchk(IDX_IRC_TRIM_HI, 8'h0A);
        wr(IDX_GUARD, 8'hFF);
        rdchk(IDX_GUARD, 8'h01);
        wr(IDX_IRC_TRIM_HI, 8'h05);
        rdchk(IDX_IRC_TRIM_HI, 8'h0A);
        $display("test guard done");
    endtask

    task automatic t_unmapped;
        logic [31:0] rd;
        logic err;
        apb(1'b0, 12'h3F0, 8'h00, rd, err);
        check(err, 1'b1, "unmapped error flag");
        check(rd, 32'h0, "unmapped data");
        $display("test unmapped done");
    endtask

    task automatic t_test_reg;
        rdchk(IDX_TEST_TWO, 8'h28);
        reduced_perf_state <= 1'b1;
        special_mode <= 1'b1;
        cycles(5);
        wr(IDX_TEST_TWO, 8'h01);
        rdchk(IDX_TEST_TWO, 8'h38);
        special_mode <= 1'b0;
        wr(IDX_TEST_TWO, TEST_UNLOCK_KEY);
        wr(IDX_TEST_TWO, 8'h01);
        rdchk(IDX_TEST_TWO, 8'h38);
        special_mode <= 1'b1;
        cycles(5);
        wr(IDX_TEST_TWO, 8'h01);
        rdchk(IDX_TEST_TWO, 8'h39);
        periodic_timer_en <= 1'b1;
        cycles(6);
        check(aux_clock_pin, 1'b1, "aux pin routed");
        aux_clock_in <= 1'b0;
        cycles(6);
        check(aux_clock_pin, 1'b0, "aux pin follows clock");
        aux_clock_in <= 1'b1;
        periodic_external_access <= 1'b1;
        cycles(6);
        check(aux_clock_pin, 1'b0, "aux pin blocked");
        $display("test factory register done");
    endtask

    task automatic t_lock;
        wait_lock(1'b1);
        check((loop_vco_khz > 63000) && (loop_vco_khz < 65000), 1'b1,
            "locked vco");
        out_ratio(4);
        check(lock_irq, 1'b0, "request masked");
        wr(IDX_LOOP_IRQ_EN, 8'h10);
        cycles(2);
        check(lock_irq, 1'b1, "request on toggle");
        wr(IDX_LOOP_FLAGS, 8'h10);
        cycles(2);
        check(lock_irq, 1'b0, "request cleared");
        wr(IDX_LOOP_FLAGS, 8'h00);
        rdchk(IDX_LOOP_FLAGS, 8'h08);
        wr(IDX_POST_DIV, 8'h00);
        out_ratio(1);
        $display("test lock done");
    endtask

    task automatic t_osc;
        wr(IDX_GUARD, GUARD_OPEN_KEY);
        wr(IDX_REF_DIV, 8'h41);
        wr(IDX_EXT_OSC, 8'h80);
        cycles(4);
        check(pll_ref_khz, 24'd4000 / 2, "xtal reference");
        wait_lock(1'b0);
        cycles(2);
        check(lock_irq, 1'b1, "request on unlock");
        check(phase_up, 1'b1, "correction up");
        rdchk(IDX_EXT_OSC, 8'hA0);
        wr(IDX_GUARD, 8'h01);
        wr(IDX_EXT_OSC, 8'h00);
        rdchk(IDX_EXT_OSC, 8'hA0);
        wr(IDX_GUARD, GUARD_OPEN_KEY);
        wr(IDX_CLOCK_SEL, 8'h00);
        cycles(3);
        check(bus_khz, 24'd4000, "bus from xtal");
        wr(IDX_EXT_OSC, 8'h00);
        rdchk(IDX_EXT_OSC, 8'hA0);
        wr(IDX_CLOCK_SEL, 8'h80);
        wr(IDX_EXT_OSC, 8'h00);
        cycles(4);
        check(pll_ref_khz, IRC_KHZ, "internal reference");
        // vco overshot while the reference was doubled, so it must steer down
        check(phase_dn, 1'b1, "correction down");
        rdchk(IDX_EXT_OSC, 8'h20);
        $display("test oscillator done");
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        #400000;
        err_count++;
        print_verdict();
    end

    // main sequence
    initial begin
        presetn <= 1'b0;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 12'h000;
        pwdata <= 32'h0;
        special_mode <= 1'b0;
        core_lvr_above <= 1'b1;
        flash_lvr_above <= 1'b0;
        io_lvr_above <= 1'b1;
        reduced_perf_state <= 1'b0;
        periodic_timer_en <= 1'b0;
        periodic_external_access <= 1'b0;
        aux_clock_in <= 1'b1;
        xtal_khz <= 24'd4000;
        cycles(2);
        presetn <= 1'b1;
        cycles(5);
        t_reset();
        t_guard();
        t_unmapped();
        t_test_reg();
        t_lock();
        t_osc();
        print_verdict();
    end
endmodule
